/* File: core/uart_tx_core.sv */
// asynchronous serial transmitter: one-deep buffer, shifter, flags and requests.
// assumes the write, clear and acknowledge strobes are single-cycle and synchronous.
`timescale 1ns/1ns
module uart_tx_core
	import uart_tx_pkg::*;
#(
	parameter int unsigned DW = DIV_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	input wire logic tx_enable_bit,
	input wire logic double_speed_sel,
	input wire logic [DW-1:0] baud_divisor,
	input wire frame_cfg_t frame_cfg,
	input wire logic global_irq_en,
	input wire logic buffer_empty_irq_en,
	input wire logic frame_done_irq_en,
	// character write
	input wire logic data_wr,
	input wire logic [7:0] tx_data_reg,
	input wire logic ninth_tx_bit,
	// flag clears
	input wire logic empty_clr,
	input wire logic done_clr,
	input wire logic done_ack,
	// serial pin
	output logic serial_out,
	output logic serial_oe_n,
	// status and requests
	output logic buffer_empty_flag,
	output logic frame_done_flag,
	output logic buffer_empty_irq,
	output logic frame_done_irq,
	output logic tx_active
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	tx_state_t state_q, state_d;
	logic [8:0] buf_q, buf_d;
	logic buf_full_q, buf_full_d;
	logic [8:0] shift_q, shift_d;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	frame_cfg_t cfg_q, cfg_d;
	logic par_q, par_d;
	logic empty_q, empty_d;
	logic done_q, done_d;
	logic be_irq_q, be_irq_d;
	logic fd_irq_q, fd_irq_d;
	logic line_q, line_d;
	logic oe_n_q, oe_n_d;
	logic active_q, active_d;
	logic bit_tick;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire in_idle = (state_q == S_IDLE);
	wire [3:0] nbits = data_bits(cfg_q.char_size);
	wire last_data = (bit_cnt_q == 4'(nbits - 4'h1));
	wire par_on = cfg_q.parity_mode[PAR_EN_BIT];
	wire two_stop = cfg_q.stop_bits_sel;
	wire frame_end = bit_tick && (((state_q == S_STOP1) && !two_stop)
		|| (state_q == S_STOP2));
	// a cleared enable stops new frames but never the one in flight
	wire load = buf_full_q && tx_enable_bit && (in_idle || frame_end);
	wire done_set = frame_end && !buf_full_q;

	baud_tick_gen #(
		.DW(DW)
	) u_baud (
		.clk(clk),
		.rst(rst),
		.run(!in_idle),
		.double_speed_sel(double_speed_sel),
		.baud_divisor(baud_divisor),
		.bit_tick(bit_tick)
	);

	// ------------------------------------------------------------
	// frame sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: begin
				if (load) begin
					state_d = S_START;
				end
			end
			S_START: begin
				if (bit_tick) begin
					state_d = S_DATA;
				end
			end
			S_DATA: begin
				if (bit_tick && last_data) begin
					state_d = par_on ? S_PARITY : S_STOP1;
				end
			end
			S_PARITY: begin
				if (bit_tick) begin
					state_d = S_STOP1;
				end
			end
			S_STOP1: begin
				if (bit_tick) begin
					state_d = two_stop ? S_STOP2 : (load ? S_START : S_IDLE);
				end
			end
			S_STOP2: begin
				if (bit_tick) begin
					state_d = load ? S_START : S_IDLE;
				end
			end
			default: state_d = S_IDLE;
		endcase
	end

	// frame format is captured at load so a mid-frame change cannot tear a frame
	assign cfg_d = load ? frame_cfg : cfg_q;
	assign par_d = load ? parity_of(buf_q, frame_cfg) : par_q;
	assign shift_d = load ? buf_q : ((state_q == S_DATA && bit_tick) ? {1'b0, shift_q[8:1]}
		: shift_q);
	assign bit_cnt_d = load ? 4'h0 : ((state_q == S_DATA && bit_tick) ? bit_cnt_q + 4'h1
		: bit_cnt_q);

	// ------------------------------------------------------------
	// buffer and flags
	// ------------------------------------------------------------
	// a write in the load cycle refills the buffer behind the character leaving it
	assign buf_d = data_wr ? {ninth_tx_bit, tx_data_reg} : buf_q;
	assign buf_full_d = data_wr || (buf_full_q && !load);
	// set wins over a software clear in the same cycle
	assign empty_d = (load && !data_wr) || (empty_q && !data_wr && !empty_clr);
	assign done_d = done_set || (done_q && !done_clr && !done_ack);
	assign be_irq_d = empty_d && buffer_empty_irq_en && global_irq_en;
	assign fd_irq_d = done_d && frame_done_irq_en && global_irq_en;

	// ------------------------------------------------------------
	// pin
	// ------------------------------------------------------------
	assign active_d = tx_enable_bit || (state_d != S_IDLE);
	assign oe_n_d = !active_d;

	always_comb begin
		line_d = LINE_IDLE;
		unique case (state_d)
			S_START: line_d = 1'b0;
			S_DATA: line_d = shift_d[0];
			S_PARITY: line_d = par_d;
			default: line_d = LINE_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;
			shift_q <= '0;
			bit_cnt_q <= '0;
			cfg_q <= '0;
			par_q <= 1'b0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			bit_cnt_q <= bit_cnt_d;
			cfg_q <= cfg_d;
			par_q <= par_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			buf_q <= '0;
			buf_full_q <= 1'b0;
			empty_q <= EMPTY_RESET;
			done_q <= 1'b0;
			be_irq_q <= 1'b0;
			fd_irq_q <= 1'b0;
		end else begin
			buf_q <= buf_d;
			buf_full_q <= buf_full_d;
			empty_q <= empty_d;
			done_q <= done_d;
			be_irq_q <= be_irq_d;
			fd_irq_q <= fd_irq_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			line_q <= LINE_IDLE;
			oe_n_q <= 1'b1;
			active_q <= 1'b0;
		end else begin
			line_q <= line_d;
			oe_n_q <= oe_n_d;
			active_q <= active_d;
		end
	end

	assign serial_out = line_q;
	assign serial_oe_n = oe_n_q;
	assign buffer_empty_flag = empty_q;
	assign frame_done_flag = done_q;
	assign buffer_empty_irq = be_irq_q;
	assign frame_done_irq = fd_irq_q;
	assign tx_active = active_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [8:0] sent_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sent_q <= '0;
		end else if (load) begin
			sent_q <= buf_q;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	start_low_a: assert property (state_q == S_START |-> !serial_out)
		else $error("start bit is not low");

	idle_high_a: assert property (in_idle && !serial_oe_n |-> serial_out)
		else $error("idle line not high while driven");

	data_order_a: assert property (state_q == S_DATA |-> serial_out == sent_q[bit_cnt_q])
		else $error("data bit out of order");

	parity_val_a: assert property (state_q == S_PARITY |->
		serial_out == parity_of(sent_q, cfg_q))
		else $error("parity bit wrong");

	parity_slot_a: assert property (state_q == S_DATA && bit_tick && last_data |=>
		state_q == (par_on ? S_PARITY : S_STOP1))
		else $error("parity slot wrong after last data bit");

	write_start_a: assert property (data_wr && tx_enable_bit && in_idle && !buf_full_q
		|=> !buffer_empty_flag ##1 state_q == S_START)
		else $error("write did not start a frame");

	empty_set_a: assert property (load && !data_wr |=> buffer_empty_flag)
		else $error("empty flag not set after buffer moved");

	empty_hold_a: assert property (buffer_empty_flag && !empty_clr && !data_wr
		|=> buffer_empty_flag)
		else $error("empty flag lost without clear");

	done_cause_a: assert property ($rose(frame_done_flag) |->
		$past(frame_end) && !$past(buf_full_q))
		else $error("done flag set without a finished frame");

	done_clear_a: assert property (frame_done_flag && (done_ack || done_clr) && !done_set
		|=> !frame_done_flag)
		else $error("done flag not cleared");

	// the request flop resets low while the flag resets high, so the first edge is skipped
	empty_irq_a: assert property (!$past(rst) |-> buffer_empty_irq == (buffer_empty_flag
		&& $past(buffer_empty_irq_en) && $past(global_irq_en)))
		else $error("empty request does not follow flag and enables");

	done_irq_a: assert property (frame_done_irq == (frame_done_flag
		&& $past(frame_done_irq_en) && $past(global_irq_en)))
		else $error("done request does not follow flag and enables");

	busy_drive_a: assert property (!in_idle |-> !serial_oe_n)
		else $error("pin released during a frame");

	release_a: assert property (!tx_enable_bit && in_idle |=> serial_oe_n)
		else $error("pin not released when disabled");

	back_to_back_c: cover property (state_q == S_STOP1 && frame_end && load);
	nine_bit_parity_c: cover property (state_q == S_PARITY && cfg_q.char_size == SIZE_9);
	two_stop_c: cover property (state_q == S_STOP2 && bit_tick);
	disable_mid_c: cover property (!tx_enable_bit && state_q == S_DATA);

endmodule

/* File: core/uart_tx_pkg.sv */
// constants, types and helper functions for the asynchronous serial transmitter.
// assumes a single 100 MHz system clock and configuration held stable by software.
//
// Function
// - bit time is 16*(divisor+1) clocks, or 8*(divisor+1) with double speed.
// - any frame of 5..9 data bits, none/even/odd parity, one or two stops.
// - order is start, data lsb first, optional parity, then stop bits.
// - line idles high; a low start bit marks the frame's beginning.
// - after a frame, the next starts with no gap or the line idles high.
// - even parity is the xor of the data bits; odd parity is its inverse.
// - parity mode bit 1 inserts parity after the msb, otherwise none is sent.
// - one frame format setting serves both directions of the channel.
// - writing a character fills the buffer and starts its transmission.
// - buffer moves to shifter when idle or right after the last stop bit.
// - empty flag tracks the buffer; writing zero clears it, one does nothing.
// - empty interrupt is asserted while the flag and both enables are set.
// - done flag sets when the frame has left and the buffer is empty.
// - done flag clears on interrupt acknowledge or a software write of zero.
// - done interrupt is asserted while the flag and both enables are set.
// - disabling mid-frame lets that frame finish before going inactive.
// - once disabled, the serial pin is released for general purpose use.
package uart_tx_pkg;

	// ------------------------------------------------------------
	// baud generation
	// ------------------------------------------------------------
	localparam int unsigned DIV_W = 8;
	localparam int unsigned PERIOD_W = 13;
	localparam logic [4:0] PRESCALE_NORMAL = 5'h10;
	localparam logic [4:0] PRESCALE_DOUBLE = 5'h08;

	// ------------------------------------------------------------
	// frame format
	// ------------------------------------------------------------
	localparam logic [2:0] SIZE_5 = 3'h0;
	localparam logic [2:0] SIZE_6 = 3'h1;
	localparam logic [2:0] SIZE_7 = 3'h2;
	localparam logic [2:0] SIZE_9 = 3'h7;
	localparam int unsigned PAR_EN_BIT = 1;
	localparam int unsigned PAR_ODD_BIT = 0;
	localparam logic EMPTY_RESET = 1'b1;
	localparam logic LINE_IDLE = 1'b1;

	typedef struct packed {
		logic [2:0] char_size;
		logic [1:0] parity_mode;
		logic stop_bits_sel;
	} frame_cfg_t;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_START = 6'h02,
		S_DATA = 6'h04,
		S_PARITY = 6'h08,
		S_STOP1 = 6'h10,
		S_STOP2 = 6'h20
	} tx_state_t;

	// number of data bits for a size code; unused codes fall back to eight
	function automatic logic [3:0] data_bits(input logic [2:0] size);
		unique case (size)
			SIZE_5: data_bits = 4'h5;
			SIZE_6: data_bits = 4'h6;
			SIZE_7: data_bits = 4'h7;
			SIZE_9: data_bits = 4'h9;
			default: data_bits = 4'h8;
		endcase
	endfunction

	// xor of the used data bits, inverted for odd parity
	function automatic logic parity_of(input logic [8:0] data, input frame_cfg_t cfg);
		logic [3:0] n;
		logic p;
		n = data_bits(cfg.char_size);
		p = cfg.parity_mode[PAR_ODD_BIT];
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n)) begin
				p = p ^ data[i];
			end
		end
		parity_of = p;
	endfunction

	function automatic logic [PERIOD_W-1:0] bit_period(input logic [DIV_W-1:0] div,
		input logic dbl);
		logic [4:0] pre;
		pre = dbl ? PRESCALE_DOUBLE : PRESCALE_NORMAL;
		bit_period = PERIOD_W'({8'h00, pre} * ({5'h00, div} + 13'h0001));
	endfunction

endpackage

/* File: core/baud_tick_gen.sv */
// bit-rate tick generator for the serial transmitter.
// assumes run is held high for the whole of a frame and low between frames.
`timescale 1ns/1ns
module baud_tick_gen
	import uart_tx_pkg::*;
#(
	parameter int unsigned DW = DIV_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic double_speed_sel,
	input wire logic [DW-1:0] baud_divisor,
	// tick at the end of every bit time
	output logic bit_tick
);

	logic [DW-1:0] div_q;
	logic [4:0] pre_q;
	logic [PERIOD_W-1:0] len_q;
	wire sub_tick = (div_q == baud_divisor);
	wire [4:0] pre_last = (double_speed_sel ? PRESCALE_DOUBLE : PRESCALE_NORMAL) - 5'h01;

	// counters restart when run drops, so every frame starts with a full start bit
	assign bit_tick = run && sub_tick && (pre_q == pre_last);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q <= '0;
			pre_q <= '0;
		end else if (!run) begin
			div_q <= '0;
			pre_q <= '0;
		end else if (sub_tick) begin
			div_q <= '0;
			pre_q <= (pre_q == pre_last) ? 5'h00 : pre_q + 5'h01;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			len_q <= '0;
		end else if (!run || bit_tick) begin
			len_q <= '0;
		end else begin
			len_q <= len_q + 1'b1;
		end
	end

	bit_time_a: assert property (@(posedge clk) disable iff (rst)
		bit_tick |-> len_q == bit_period(8'(baud_divisor), double_speed_sel) - 13'h0001)
		else $error("bit time differs from prescale times divisor plus one");

endmodule

/* File: verification/uart_rx_model.sv */
// behavioural remote receiver that watches the serial line and decodes frames.
// assumes the line has a pull-up, and that every character starts with data bit 0 high,
// so the start bit alone sets the measured bit time.
`timescale 1ns/1ns
module uart_rx_model
	import uart_tx_pkg::*;
(
	// clock and line
	input wire logic clk,
	input wire logic line,
	// frame format shared with the transmitter
	input wire frame_cfg_t cfg,
	// last decoded frame
	output logic [8:0] data,
	output logic par,
	output logic [1:0] stops,
	output int frames,
	output int len
);
	int nb;

	initial begin
		frames = 0;
		len = 0;
		data = 9'h000;
		par = 1'b0;
		stops = 2'h0;
		forever begin
			@(posedge clk);
			// a falling edge out of the idle level opens a frame
			if (line === 1'b0) begin
				len = 1;
				@(posedge clk);
				while (line === 1'b0) begin
					len++;
					@(posedge clk);
				end
				nb = (cfg.char_size == 3'h0) ? 5 : (cfg.char_size == 3'h1) ? 6 :
					(cfg.char_size == 3'h2) ? 7 : (cfg.char_size == 3'h7) ? 9 : 8;
				data = 9'h000;
				repeat (len / 2) @(posedge clk);
				for (int i = 0; i < nb; i++) begin
					data[i] = line;
					repeat (len) @(posedge clk);
				end
				if (cfg.parity_mode[1]) begin
					par = line;
					repeat (len) @(posedge clk);
				end
				stops[0] = line;
				stops[1] = 1'b1;
				if (cfg.stop_bits_sel) begin
					repeat (len) @(posedge clk);
					stops[1] = line;
				end
				frames++;
			end
		end
	end
endmodule

/* File: verification/tb.sv */
// self-checking bench for the serial transmitter core with a remote receiver model.
// assumes the pin has a pull-up, so a released line reads high.
`timescale 1ns/1ns
module tb;
	import uart_tx_pkg::*;

	// ------------------------------------------------------------
	// signals and rows
	// ------------------------------------------------------------
	typedef struct {
		logic [2:0] sz;
		logic [1:0] pm;
		logic sb;
		logic dbl;
		logic [7:0] div;
		logic [8:0] d;
		int nb;
		int t;
	} row_t;
	row_t rows [7] = '{
		'{3'h0, 2'h2, 1'h0, 1'h0, 8'h00, 9'h1f5, 5, 16},
		'{3'h1, 2'h3, 1'h1, 1'h1, 8'h00, 9'h02b, 6, 8},
		'{3'h2, 2'h0, 1'h1, 1'h0, 8'h01, 9'h07f, 7, 32},
		'{3'h3, 2'h3, 1'h0, 1'h1, 8'h02, 9'h0a5, 8, 24},
		'{3'h7, 2'h2, 1'h0, 1'h0, 8'h00, 9'h1c3, 9, 16},
		'{3'h7, 2'h3, 1'h1, 1'h1, 8'h01, 9'h133, 9, 16},
		'{3'h5, 2'h2, 1'h1, 1'h0, 8'h00, 9'h1ff, 8, 16}
	};
	logic clk = 1'b0;
	logic rst, tx_enable_bit, double_speed_sel, global_irq_en;
	logic buffer_empty_irq_en, frame_done_irq_en, data_wr, ninth_tx_bit;
	logic empty_clr, done_clr, done_ack;
	logic [7:0] baud_divisor, tx_data_reg;
	frame_cfg_t frame_cfg;
	logic serial_out, serial_oe_n, buffer_empty_flag, frame_done_flag;
	logic buffer_empty_irq, frame_done_irq, tx_active;
	logic [8:0] rx_data;
	logic rx_par;
	logic [1:0] rx_stops;
	int rx_frames, rx_len;
	int n_mismatch = 0;
	int compares = 0;
	// pull-up on the pin
	wire logic line = serial_oe_n ? 1'b1 : serial_out;

	always #5 clk = ~clk;

	uart_tx_core #(.DW(8)) i_uart_tx_core (.clk(clk), .rst(rst), .tx_enable_bit(tx_enable_bit),
		.double_speed_sel(double_speed_sel), .baud_divisor(baud_divisor), .frame_cfg(frame_cfg),
		.global_irq_en(global_irq_en), .buffer_empty_irq_en(buffer_empty_irq_en),
		.frame_done_irq_en(frame_done_irq_en), .data_wr(data_wr), .tx_data_reg(tx_data_reg),
		.ninth_tx_bit(ninth_tx_bit), .empty_clr(empty_clr), .done_clr(done_clr),
		.done_ack(done_ack), .serial_out(serial_out), .serial_oe_n(serial_oe_n),
		.buffer_empty_flag(buffer_empty_flag), .frame_done_flag(frame_done_flag),
		.buffer_empty_irq(buffer_empty_irq), .frame_done_irq(frame_done_irq),
		.tx_active(tx_active));

	uart_rx_model i_uart_rx_model (.clk(clk), .line(line), .cfg(frame_cfg), .data(rx_data),
		.par(rx_par), .stops(rx_stops), .frames(rx_frames), .len(rx_len));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic end_of_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ninth bit travels in the same cycle as the low byte
	task automatic send(input logic [8:0] d);
		@(negedge clk);
		ninth_tx_bit = d[8];
		tx_data_reg = d[7:0];
		data_wr = 1'b1;
		@(negedge clk);
		data_wr = 1'b0;
	endtask

	// 0: write zero to done, 1: acknowledge done, 2: write zero to empty
	task automatic pulse(input int which);
		@(negedge clk);
		done_clr = (which == 0);
		done_ack = (which == 1);
		empty_clr = (which == 2);
		@(negedge clk);
		done_clr = 1'b0;
		done_ack = 1'b0;
		empty_clr = 1'b0;
	endtask

	task automatic wait_level(input logic want_done, input int limit);
		int k;
		k = 0;
		while ((want_done ? frame_done_flag !== 1'b1 : line !== 1'b0) && k < limit) begin
			@(negedge clk);
			k++;
		end
		if (k >= limit) begin
			n_mismatch++;
			$display("[ERR] %0t wait ran out", $time);
		end
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		int f0;
		int k;
		logic [8:0] m;
		rst = 1'b1;
		tx_enable_bit = 1'b1;
		double_speed_sel = 1'b0;
		baud_divisor = 8'h00;
		frame_cfg = 6'h00;
		global_irq_en = 1'b1;
		buffer_empty_irq_en = 1'b1;
		frame_done_irq_en = 1'b1;
		data_wr = 1'b0;
		tx_data_reg = 8'h00;
		ninth_tx_bit = 1'b0;
		empty_clr = 1'b0;
		done_clr = 1'b0;
		done_ack = 1'b0;
		repeat (4) @(negedge clk);
		chk(16'({serial_out, serial_oe_n, buffer_empty_flag, frame_done_flag, buffer_empty_irq,
			frame_done_irq, tx_active}), 16'h0070, "reset state");
		rst = 1'b0;
		repeat (2) @(negedge clk);
		chk(16'({serial_out, serial_oe_n, tx_active, buffer_empty_irq}), 16'hb, "idle");
		for (int r = 0; r < 7; r++) begin
			f0 = rx_frames;
			m = 9'((10'h001 << rows[r].nb) - 10'h001);
			frame_cfg = {rows[r].sz, rows[r].pm, rows[r].sb};
			double_speed_sel = rows[r].dbl;
			baud_divisor = rows[r].div;
			send(rows[r].d);
			wait_level(1'b1, 3000);
			chk(16'(rx_frames), 16'(f0 + 1), "frame count");
			chk(16'(rx_len), 16'(rows[r].t), "bit time");
			chk(16'(rx_data), 16'(rows[r].d & m), "data");
			if (rows[r].pm[1]) begin
				chk(16'(rx_par), 16'(^(rows[r].d & m) ^ rows[r].pm[0]), "parity");
			end
			chk(16'(rx_stops), 16'h3, "stop bits");
			chk(16'({frame_done_irq, buffer_empty_flag}), 16'h3, "end flags");
			pulse(r % 2);
			chk(16'({frame_done_flag, frame_done_irq}), 16'h0, "done cleared");
		end
		// second character queued behind a running frame
		frame_cfg = 6'h18;
		double_speed_sel = 1'b0;
		baud_divisor = 8'h00;
		f0 = rx_frames;
		send(9'h0c1);
		wait_level(1'b0, 100);
		send(9'h03d);
		chk(16'(buffer_empty_flag), 16'h0, "buffer held");
		k = 0;
		while (rx_frames < f0 + 1 && k < 400) begin
			@(negedge clk);
			k++;
		end
		k = 0;
		while (line !== 1'b0 && k < 20) begin
			@(negedge clk);
			k++;
		end
		chk(16'(k <= 10), 16'h1, "gap between frames");
		chk(16'(frame_done_flag), 16'h0, "done with data left");
		wait_level(1'b1, 3000);
		chk(16'({7'h00, rx_data}), 16'h003d, "queued data");
		pulse(2);
		chk(16'({buffer_empty_flag, buffer_empty_irq}), 16'h0, "empty cleared");
		pulse(0);
		// disable in mid-frame with interrupts masked
		global_irq_en = 1'b0;
		f0 = rx_frames;
		send(9'h055);
		wait_level(1'b0, 100);
		tx_enable_bit = 1'b0;
		wait_level(1'b1, 3000);
		chk(16'({7'h00, rx_data}), 16'h0055, "frame after disable");
		chk(16'({frame_done_irq, buffer_empty_irq}), 16'h0, "masked requests");
		repeat (2) @(negedge clk);
		chk(16'({serial_oe_n, tx_active}), 16'h2, "pin released");
		// a character written while disabled waits for the enable
		pulse(1);
		f0 = rx_frames;
		send(9'h0e7);
		repeat (100) @(negedge clk);
		chk(16'({rx_frames == f0, buffer_empty_flag}), 16'h2, "held while off");
		global_irq_en = 1'b1;
		tx_enable_bit = 1'b1;
		wait_level(1'b1, 3000);
		chk(16'({7'h00, rx_data}), 16'h00e7, "sent after enable");
		chk(16'(frame_done_irq), 16'h1, "done request");
		// own enables masked: both flags stay up, both requests drop
		buffer_empty_irq_en = 1'b0;
		frame_done_irq_en = 1'b0;
		repeat (2) @(negedge clk);
		chk(16'({buffer_empty_irq, frame_done_irq, buffer_empty_flag, frame_done_flag}), 16'h3,
			"own enables off");
		end_of_test();
	end

	initial begin
		#200_000;
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test();
	end
endmodule
